// [serdes_rx_parallel_status_port.sv]
// Receive word assembly, 8b/10b decode, word FIFO and line status outputs.
// Assumes recovered bits arrive with a one-cycle strobe from CDR logic on clk,
// and that the shared system clock pin is muxed outside from the enable below.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module rx_word_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             inValid,
    output wire logic             inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output wire logic             outValid,
    input  wire logic             outReady,
    output wire logic [WIDTH-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr;
    logic [PW-1:0]    rdPtr;
    logic [CW-1:0]    count;

    wire logic doWrite = inValid && inReady;
    wire logic doRead  = outValid && outReady;

    assign inReady  = (count != CNT_FULL);
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PTR_LAST) ? '0 : PW'(p + 1'b1);
    endfunction : bump

    always_ff @(posedge clk)
    begin
        if (doWrite)
            mem[wrPtr] <= inData;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            if (doWrite)
                wrPtr <= bump(wrPtr);
            if (doRead)
                rdPtr <= bump(rdPtr);
            if (doWrite && !doRead)
                count <= CW'(count + 1'b1);
            else if (doRead && !doWrite)
                count <= CW'(count - 1'b1);
        end
    end

    default clocking fcb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_fifo_no_over: assert property (count == CNT_FULL && inValid && !outReady
        |=> count == CNT_FULL)
        else $error("FIFO count moved while full and stalled");
endmodule : rx_word_fifo

////////////////////////////////////////////////////////////////////////////////
module serdes_rx_parallel_status_port
    import serdes_rx_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Recovered bit stream from the CDR, same clock
    input  wire logic              recoveredBit,
    input  wire logic              recoveredBitValid,
    // Asynchronous control and status pins
    input  wire logic              rxPllLocked,
    input  wire logic              signalDetect,
    input  wire logic              byteModeSelect,
    input  wire logic              word_align_enable,
    input  wire logic              rx_clock_direction_select,
    input  wire logic              operating_select,
    // Receive word clock, two-way pin
    input  wire logic              rx_word_clock_in,
    output logic                   rx_word_clock_out,
    output logic                   rx_word_clock_oe,
    // Receive word and line status
    output logic [WORD_W-1:0]      rx_word_out,
    output logic                   signal_lost_flag,
    output logic                   rx_pll_unlock_flag,
    output logic                   comma_found_flag,
    output logic                   system_clock_out_enable
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [SYNC_W-1:0] pinMeta;
    logic [SYNC_W-1:0] pinSync;
    logic              wordClockLast;

    wire logic [SYNC_W-1:0] pinRaw = {rx_word_clock_in, operating_select,
        rx_clock_direction_select, word_align_enable, byteModeSelect,
        signalDetect, rxPllLocked};

    wire logic lockedS   = pinSync[S_LOCK];
    wire logic sigDetS   = pinSync[S_SIGDT];
    wire logic byteMode  = pinSync[S_BYTE];
    wire logic alignEnS  = pinSync[S_ALIGN];
    wire logic readMode  = pinSync[S_READ];
    wire logic opSelS    = pinSync[S_OPSEL];
    wire logic wordClkS  = pinSync[S_WCLK];
    wire logic wordEdge  = wordClkS ^ wordClockLast;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinMeta       <= SYNC_RST;
            pinSync       <= SYNC_RST;
            wordClockLast <= 1'b0;
        end
        else
        begin
            pinMeta       <= pinRaw;
            pinSync       <= pinMeta;
            wordClockLast <= wordClkS;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word assembly and comma alignment
    logic [WORD_W-1:0] shift;
    logic [3:0]        bitCount;

    // Newest bit enters at the top; bit a ends at position 0
    wire logic [WORD_W-1:0] next_shift = {recoveredBit, shift[WORD_W-1:1]};
    wire logic commaSeen = recoveredBitValid && lockedS
        && (next_shift[6:0] == COMMA_NEG || next_shift[6:0] == COMMA_POS);
    wire logic alignHit  = commaSeen && alignEnS;
    wire logic wordDone  = recoveredBitValid && lockedS
        && (bitCount == BIT_CNT_LAST || alignHit);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift    <= WORD_RST;
            bitCount <= BIT_CNT_RST;
        end
        else if (!lockedS)
            bitCount <= BIT_CNT_RST;
        else if (recoveredBitValid)
        begin
            shift    <= next_shift;
            bitCount <= wordDone ? BIT_CNT_RST : 4'(bitCount + 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // 8b/10b decode; running disparity is not checked, only code validity
    function automatic logic [5:0] dec6(input logic [5:0] c);
        logic [5:0] r;
        r = '0;
        for (int i = 0; i < 32; i++)
            if (c == ENC5[i] || (c == ~ENC5[i] && ($countones(ENC5[i]) != 3 || i == 7)))
                r = {1'b1, 5'(i)};
        return r;
    endfunction : dec6

    function automatic logic [3:0] dec4(input logic [3:0] c);
        logic [3:0] r;
        r = '0;
        for (int i = 0; i < 8; i++)
            if (c == ENC3[i] || (c == ~ENC3[i] && ($countones(ENC3[i]) != 2 || i == 3)))
                r = {1'b1, 3'(i)};
        if (c == ALT7_NEG || c == ALT7_POS)
            r = 4'h F;
        return r;
    endfunction : dec4

    wire logic [5:0] code6 = {next_shift[0], next_shift[1], next_shift[2],
                              next_shift[3], next_shift[4], next_shift[5]};
    wire logic [3:0] code4 = {next_shift[6], next_shift[7], next_shift[8], next_shift[9]};
    wire logic       isK28 = (code6 == K28_NEG) || (code6 == K28_POS);
    // After the positive K28 group (110000) the fghj bits come complemented
    wire logic [3:0] code4Eff = (code6 == K28_POS) ? ~code4 : code4;
    wire logic [5:0] d6 = dec6(code6);
    wire logic [3:0] d4 = dec4(code4Eff);
    wire logic       alt7 = (code4 == ALT7_NEG) || (code4 == ALT7_POS);
    wire logic       kx7 = alt7 && d6[5] && (d6[4:0] == 5'h17 || d6[4:0] == 5'h1B
                          || d6[4:0] == 5'h1D || d6[4:0] == 5'h1E);
    wire logic       isK = isK28 || kx7;
    wire logic [4:0] val5 = isK28 ? 5'h1C : d6[4:0];
    wire logic       codeOk = (isK28 || d6[5]) && d4[3];
    wire logic [WORD_W-1:0] byteWord = {~codeOk, isK, d4[2:0], val5};
    wire logic [WORD_W-1:0] pushWord = byteMode ? byteWord : next_shift;

    ////////////////////////////////////////////////////////////////////////////
    // Word FIFO and drain; a word that finds it full is dropped silently
    wire logic              fifoInReady;
    wire logic              fifoOutValid;
    wire logic [WORD_W-1:0] fifoOutData;
    wire logic              push = wordDone && fifoInReady;
    // Write mode drains as fast as words come; read mode waits for host edges
    wire logic              drainTick = readMode ? wordEdge : fifoOutValid;
    wire logic              pop = drainTick && fifoOutValid;

    rx_word_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) i_rx_word_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .inValid  (wordDone),
        .inReady  (fifoInReady),
        .inData   (pushWord),
        .outValid (fifoOutValid),
        .outReady (drainTick),
        .outData  (fifoOutData)
    );

    // An edge with nothing queued keeps the word but drops the violation bit
    wire logic [WORD_W-1:0] idleWord = {rx_word_out[9] && !byteMode, rx_word_out[8:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Link state and status outputs
    link_state_t linkState;
    link_state_t next_linkState;

    always_comb
    begin
        next_linkState = linkState;
        unique case (linkState)
            LINK_DOWN:  next_linkState = commaSeen ? LINK_FOUND : LINK_HUNT;
            LINK_HUNT:  next_linkState = commaSeen ? LINK_FOUND : LINK_HUNT;
            LINK_FOUND: next_linkState = LINK_FOUND;
            default:    next_linkState = LINK_DOWN;
        endcase
        if (!lockedS)
            next_linkState = LINK_DOWN;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            linkState               <= LINK_DOWN;
            rx_word_out             <= WORD_RST;
            rx_word_clock_out       <= 1'b0;
            rx_word_clock_oe        <= 1'b0;
            signal_lost_flag        <= 1'b0;
            rx_pll_unlock_flag      <= 1'b1;
            comma_found_flag        <= 1'b0;
            system_clock_out_enable <= 1'b0;
        end
        else
        begin
            linkState               <= next_linkState;
            comma_found_flag        <= (next_linkState == LINK_FOUND);
            rx_pll_unlock_flag      <= !lockedS;
            signal_lost_flag        <= byteMode && !sigDetS;
            system_clock_out_enable <= !opSelS;
            rx_word_clock_oe        <= !readMode;
            if (drainTick)
                rx_word_out <= fifoOutValid ? fifoOutData : idleWord;
            if (!readMode && pop)
                rx_word_clock_out <= !rx_word_clock_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_raw_word_path: assert property (pop && !byteMode |=> rx_word_out == $past(fifoOutData))
        else $error("Raw word not presented after pop");
    a_byte_d00: assert property (push && byteMode && code6 == 6'h27 && code4 == 4'hB |-> pushWord == 10'h000)
        else $error("D0.0 did not decode to zero");
    a_k285_flag: assert property (push && byteMode
        && ((code6 == K28_NEG && code4 == 4'hA) || (code6 == K28_POS && code4 == 4'h5))
        |-> pushWord == 10'h1BC)
        else $error("K28.5 not flagged as control 0xBC");
    a_violation_flag: assert property (push && byteMode && code6 == 6'h00 |-> pushWord[9])
        else $error("Illegal group not flagged");
    a_d215_decode: assert property (push && byteMode && code6 == 6'h2A && code4 == 4'hA |-> pushWord == 10'h0B5)
        else $error("D21.5 decode wrong");
    a_write_clock_oe: assert property ($past(rst_n) && !$past(readMode)
        |-> rx_word_clock_oe)
        else $error("Word clock not driven in write mode");
    a_read_edge_update: assert property (readMode && wordEdge && fifoOutValid |=> rx_word_out == $past(fifoOutData) && !rx_word_clock_oe)
        else $error("Read edge did not update word");
    a_sysclk_enable: assert property ($past(rst_n) && !$past(opSelS)
        |-> system_clock_out_enable)
        else $error("System clock not enabled with select low");
    a_los_mode: assert property (!byteMode |=> !signal_lost_flag)
        else $error("Signal lost flag outside 8-bit mode");
    a_unlock_flag: assert property (lockedS != $past(lockedS) |=> rx_pll_unlock_flag == !$past(lockedS))
        else $error("Unlock flag does not follow lock");
    a_comma_unlock: assert property (!lockedS |=> !comma_found_flag)
        else $error("Comma flag high while unlocked");
    a_comma_set: assert property (commaSeen |=> comma_found_flag [*1] ##1 (comma_found_flag || !$past(lockedS)))
        else $error("Comma flag not set after comma");
    a_align_reset: assert property (alignHit |=> bitCount == BIT_CNT_RST)
        else $error("Word boundary not moved to comma");

endmodule : serdes_rx_parallel_status_port

// [serdes_rx_pkg.sv]
// Constants, code tables and state encodings for the receive parallel port.
// Assumes a single 10 MHz system clock domain; all asynchronous pins are synchronised on entry.
package serdes_rx_pkg;

    localparam int WORD_W     = 10;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_W     = 7;

    // Positions of the synchronised pin levels
    localparam int S_LOCK  = 0;
    localparam int S_SIGDT = 1;
    localparam int S_BYTE  = 2;
    localparam int S_ALIGN = 3;
    localparam int S_READ  = 4;
    localparam int S_OPSEL = 5;
    localparam int S_WCLK  = 6;

    // Comma in bits abcdeif of the window, bit a at position 0
    localparam logic [6:0] COMMA_NEG = 7'h7C;
    localparam logic [6:0] COMMA_POS = 7'h03;
    localparam logic [5:0] K28_NEG   = 6'h0F;
    localparam logic [5:0] K28_POS   = 6'h30;
    localparam logic [3:0] ALT7_NEG  = 4'h7;
    localparam logic [3:0] ALT7_POS  = 4'h8;

    localparam logic [3:0]        BIT_CNT_RST  = 4'h0;
    localparam logic [3:0]        BIT_CNT_LAST = 4'h9;
    localparam logic [WORD_W-1:0] WORD_RST     = 10'h000;
    localparam logic [SYNC_W-1:0] SYNC_RST     = 7'h00;

    // Primary (negative disparity) codes, abcdei and fghj with a, f as MSB
    localparam logic [5:0] ENC5 [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] ENC3 [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

    typedef enum logic [2:0] {
        LINK_DOWN  = 3'b001,
        LINK_HUNT  = 3'b010,
        LINK_FOUND = 3'b100
    } link_state_t;

endpackage : serdes_rx_pkg

// [rx_host_model.sv]
// Host framing side: drives the word clock in read mode and captures words.
// Assumes the bench resolves the two-way clock pin from the device enable.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module rx_host_model
    import serdes_rx_pkg::*;
(
    // Control from the bench
    input  wire logic              run,
    // Word port of the device
    input  wire logic [WORD_W-1:0] word,
    output logic                   hostClk
);
    logic              armed;
    logic [WORD_W-1:0] words [$];

    // Clock stands still unless run; phase unrelated to the system clock.
    // One time base paces every clock here, so no host clock drifts
    initial
    begin
        hostClk = 1'b0;
        armed = 1'b0;
        #37;
        forever
        begin
            #400;
            if (run)
            begin
                // Word latched on one edge is taken just before the next
                if (armed)
                    words.push_back(word);
                hostClk = ~hostClk;
                armed = 1'b1;
            end
            else
                armed = 1'b0;
        end
    end
endmodule : rx_host_model

// [serdes_rx_parallel_status_port_tb.sv]
// Self-checking bench for the receive parallel and status port.
// Assumes the host model in rx_host_model.sv and a 10 MHz system clock.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module serdes_rx_parallel_status_port_tb
    import serdes_rx_pkg::*;
;
    logic              clk;
    logic              rst_n;
    logic              recoveredBit;
    logic              recoveredBitValid;
    logic              rxPllLocked;
    logic              signalDetect;
    logic              byteModeSelect;
    logic              alignEnable;
    logic              readMode;
    logic              opSelect;
    logic              hostRun;
    logic              prevClkOut;
    wire logic         hostClk;
    wire logic         rxClkPin;
    logic              clkOut;
    logic              clkOe;
    logic [WORD_W-1:0] word;
    logic              lost;
    logic              unlock;
    logic              comma;
    logic              sysEn;
    logic [9:0]        q [$];
    int                mismatches;
    int                n_tests;

    // Two-way word clock pin
    assign rxClkPin = clkOe ? clkOut : hostClk;

    serdes_rx_parallel_status_port i_serdes_rx_parallel_status_port (
        .clk(clk), .rst_n(rst_n),
        .recoveredBit(recoveredBit), .recoveredBitValid(recoveredBitValid),
        .rxPllLocked(rxPllLocked), .signalDetect(signalDetect),
        .byteModeSelect(byteModeSelect), .word_align_enable(alignEnable),
        .rx_clock_direction_select(readMode), .operating_select(opSelect),
        .rx_word_clock_in(rxClkPin), .rx_word_clock_out(clkOut),
        .rx_word_clock_oe(clkOe), .rx_word_out(word),
        .signal_lost_flag(lost), .rx_pll_unlock_flag(unlock),
        .comma_found_flag(comma), .system_clock_out_enable(sysEn));

    rx_host_model i_rx_host_model (.run(hostRun), .word(word), .hostClk(hostClk));

    always #50 clk = ~clk;

    // Write mode: a word is new whenever the driven clock toggles
    always @(negedge clk)
    begin
        if (clkOe === 1'b1 && clkOut !== prevClkOut)
            q.push_back(word);
        prevClkOut = clkOut;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask : chk

    // Bit a goes first; strobe held high across all n bits sent
    task automatic sendBits(input logic [9:0] w, input int n);
        @(posedge clk);
        for (int i = 0; i < n; i++)
        begin
            recoveredBit <= w[i];
            recoveredBitValid <= 1'b1;
            @(posedge clk);
        end
        recoveredBitValid <= 1'b0;
    endtask : sendBits

    task automatic sendList(input logic [9:0] ws[$]);
        foreach (ws[i])
            sendBits(ws[i], 10);
    endtask : sendList

    task automatic checkTail(input string name, input logic [9:0] exp[$]);
        settle(8);
        if (q.size() < exp.size())
            chk(name, 10'(exp.size()), 10'(q.size()));
        else
            foreach (exp[i])
                chk(name, exp[i], q[q.size() - exp.size() + i]);
    endtask : checkTail

    task automatic close_out;
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #500_000;
        mismatches++;
        close_out();
    end

    initial
    begin
        clk = 1'b0; rst_n = 1'b0; recoveredBit = 1'b0; recoveredBitValid = 1'b0;
        rxPllLocked = 1'b0; signalDetect = 1'b0; byteModeSelect = 1'b0;
        alignEnable = 1'b0; readMode = 1'b0; opSelect = 1'b1; hostRun = 1'b0;
        prevClkOut = 1'b0; mismatches = 0; n_tests = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        settle(5);
        chk("unlock", 10'h001, 10'(unlock));
        chk("comma", 10'h000, 10'(comma));
        chk("lost", 10'h000, 10'(lost));
        chk("sysEn", 10'h000, 10'(sysEn));
        chk("oe", 10'h001, 10'(clkOe));
        // A comma while unlocked must not count
        sendBits(10'h17C, 10);
        settle(5);
        chk("comma", 10'h000, 10'(comma));
        @(posedge clk);
        rxPllLocked <= 1'b1;
        opSelect <= 1'b0;
        settle(5);
        chk("unlock", 10'h000, 10'(unlock));
        chk("sysEn", 10'h001, 10'(sysEn));
        sendList('{10'h155, 10'h1A3, 10'h2C9});
        checkTail("raw", '{10'h155, 10'h1A3, 10'h2C9});
        chk("comma", 10'h000, 10'(comma));
        sendList('{10'h17C});
        checkTail("raw", '{10'h17C});
        chk("comma", 10'h001, 10'(comma));
        @(posedge clk);
        byteModeSelect <= 1'b1;
        alignEnable <= 1'b1;
        settle(5);
        chk("lost", 10'h001, 10'(lost));
        @(posedge clk);
        signalDetect <= 1'b1;
        settle(5);
        chk("lost", 10'h000, 10'(lost));
        // Three stray bits shift the boundary until the comma realigns it
        sendBits(10'h005, 3);
        sendList('{10'h17C, 10'h1A3, 10'h155, 10'h283});
        checkTail("byte", '{10'h1BC, 10'h0C3, 10'h0B5, 10'h1BC});
        sendList('{10'h000});
        settle(8);
        chk("violation", 10'h001, 10'(q[$][9]));
        sendList('{10'h155});
        checkTail("byte", '{10'h0B5});
        @(posedge clk);
        byteModeSelect <= 1'b0;
        alignEnable <= 1'b0;
        readMode <= 1'b1;
        settle(8);
        chk("oe", 10'h000, 10'(clkOe));
        // Six words into a four-word buffer while the host clock stands still
        sendList('{10'h155, 10'h1A3, 10'h2C9, 10'h155, 10'h1A3, 10'h2C9});
        @(posedge clk);
        hostRun <= 1'b1;
        for (int k = 0; k < 200 && i_rx_host_model.words.size() < 4; k++)
            @(posedge clk);
        hostRun <= 1'b0;
        q = i_rx_host_model.words;
        checkTail("read", '{10'h155, 10'h1A3, 10'h2C9, 10'h155});
        @(posedge clk);
        rxPllLocked <= 1'b0;
        settle(5);
        chk("comma", 10'h000, 10'(comma));
        chk("unlock", 10'h001, 10'(unlock));
        close_out();
    end
endmodule : serdes_rx_parallel_status_port_tb
